/* common/afc_params.svh */
// Functional notes
// R1 - Mode bit: 1 automatic, 0 software duty
// R2 - Channel field 00 remote, 11 fastest
// R3 - Min duty code nibble, resets to 5
// R4 - Codes 0..15 map linearly to duty
// R5 - One code step per tenth of range
// R6 - Spin-up code selects 200 ms..8 s
// R7 - Frequency code selects 11.7..93.5 Hz
// R8 - Speed range field selects N 1..8
// R9 - Local threshold in 4 degree steps
// R10 - Range code selects 5..80 degrees
// R11 - Remote threshold register, same layout
// R12 - Unfiltered: new duty applied at once
// R13 - Filter enable bit selects filtered operation
// R14 - Filtered: duty ramps toward target gradually
// R15 - Sample rate sets loop updates per second
// R16 - Software sets automatic bit last
// R17 - Software writes filter register before automatic
// R18 - Fan stays on until 5 below threshold
// R19 - Both channels: larger duty drives fan
// R20 - Spin-up when fan first turns on
// R21 - Full duty during spin-up, then calculated
// R22 - Off holds zero duty; code clamps 15
`ifndef AFC_PARAMS_SVH
`define AFC_PARAMS_SVH
// Register offsets
`define AFC_OFS_CFG1 8'h00
`define AFC_OFS_FANCHAR 8'h20
`define AFC_OFS_MINDUTY 8'h22
`define AFC_OFS_FILT 8'h23
`define AFC_OFS_LTHR 8'h24
`define AFC_OFS_RTHR 8'h25
// Reset values
`define AFC_RST_CFG1 8'h80
`define AFC_RST_FANCHAR 8'h1D
`define AFC_RST_MINDUTY 8'h05
`define AFC_RST_FILT 8'h10
`define AFC_RST_LTHR 8'h44
`define AFC_RST_RTHR 8'h64
// Field positions
`define AFC_CFG1_AUTO 7
`define AFC_CFG1_CH_HI 6
`define AFC_CFG1_CH_LO 5
// Timing
`define AFC_CLK_NS 10
`define AFC_US_NS 1000
`define AFC_MS_US 1000
`define AFC_SAMPLE_SLOW_MS 16000
`define AFC_SLOTS 240
`define AFC_SLOT_PER_CODE 16
`define AFC_HYST_DEG 5
`define AFC_MAX_CODE 4'hF
`endif

/* common/afc_pkg.sv */
package afc_pkg;
    // Threshold register layout, shared by both channels
    typedef struct packed {
        logic [4:0] tmin;
        logic [2:0] range;
    } afc_thr_type;
    // Filter register layout
    typedef struct packed {
        logic spin_dis;
        logic [1:0] ramp;
        logic [2:0] rate;
        logic unused;
        logic en;
    } afc_filt_type;
    // Fan sequencing, Gray along off -> spin -> run
    typedef enum logic [1:0] {
        AFC_OFF = 2'b00,
        AFC_SPIN = 2'b01,
        AFC_RUN = 2'b11
    } afc_fan_st_type;
endpackage

/* hdl/afc_chan.sv */
`timescale 1ns/1ps
`include "afc_params.svh"
module afc_chan (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] temp,
    input wire afc_pkg::afc_thr_type thr,
    input wire logic [3:0] min_code,
    output logic running,
    output logic [3:0] duty_code
);
    logic running_r;
    logic running_nxt;
    wire [8:0] tmin_deg = {2'b00, thr.tmin, 2'b00}; // 4 degree steps [R9] [R11]
    wire [8:0] temp_w = {1'b0, temp};
    wire above = temp_w > tmin_deg;
    wire gone_cold = (temp_w + 9'd`AFC_HYST_DEG) <= tmin_deg; // [R18]
    wire [8:0] excess = above ? (temp_w - tmin_deg) : 9'h000;
    // Range/10 is 0.5,1,2,4,8 degrees: double then shift [R5] [R10]
    wire [2:0] rsh = (thr.range > 3'd4) ? 3'd4 : thr.range;
    wire [9:0] steps = {excess, 1'b0} >> rsh;
    wire [10:0] raw = {7'h00, min_code} + {1'b0, steps};

    // Clamp to full code at or above full-speed point
    function automatic logic [3:0] clamp15(input logic [10:0] v);
        clamp15 = (v > 11'd15) ? `AFC_MAX_CODE : v[3:0];
    endfunction

    assign duty_code = clamp15(raw); // [R3] [R22]
    assign running = running_r;

    // On above threshold, off only past hysteresis band
    assign running_nxt = above ? 1'b1 : (gone_cold ? 1'b0 : running_r); // [R18]

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            running_r <= 1'b0;
        end else begin
            running_r <= running_nxt;
        end
    end

    property p_hyst;
        @(posedge mclk) disable iff (!rst_n)
        running_r && !gone_cold |=> running_r;
    endproperty
    a_hyst: assert property (p_hyst) else $error("fan dropped inside hysteresis"); // [R18]

    property p_clamp;
        @(posedge mclk) disable iff (!rst_n)
        (raw > 11'd15) |-> (duty_code == 4'hF);
    endproperty
    a_clamp: assert property (p_clamp) else $error("duty code not clamped"); // [R22]
endmodule // afc_chan

/* hdl/afc_pwm.sv */
`timescale 1ns/1ps
`include "afc_params.svh"
module afc_pwm (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic slot_tick,
    input wire logic [7:0] duty_slots,
    output logic pwm_out
);
    logic [7:0] slot_r;
    logic [7:0] lat_r;
    logic pwm_r;
    wire last_slot = slot_r == 8'(`AFC_SLOTS - 1);
    wire [7:0] slot_nxt = last_slot ? 8'h00 : slot_r + 8'h01;

    // Duty latched per period so a change never chops a pulse [R4]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            slot_r <= 8'h00;
            lat_r <= 8'h00;
            pwm_r <= 1'b0;
        end else if (slot_tick) begin
            slot_r <= slot_nxt;
            lat_r <= last_slot ? duty_slots : lat_r;
            pwm_r <= slot_nxt < (last_slot ? duty_slots : lat_r);
        end
    end
    assign pwm_out = pwm_r;

    property p_zero;
        @(posedge mclk) disable iff (!rst_n)
        (lat_r == 8'h00) && !last_slot |=> !pwm_r;
    endproperty
    a_zero: assert property (p_zero) else $error("pwm high at zero duty"); // [R22]
endmodule // afc_pwm

/* hdl/afc_top.sv */
`timescale 1ns/1ps
`include "afc_params.svh"
module afc_top #(
    parameter int US_CYCLES = `AFC_US_NS / `AFC_CLK_NS,
    parameter int MS_US = `AFC_MS_US
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] local_temp,
    input wire logic [7:0] remote_temp,
    input wire logic [3:0] sw_duty_code,
    output logic pwm_out,
    output logic fan_running,
    output logic spin_active,
    output logic [3:0] tach_div
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] cfg1_r;
    logic [7:0] fanchar_r;
    logic [7:0] minduty_r;
    afc_pkg::afc_filt_type filt_r;
    afc_pkg::afc_thr_type lthr_r;
    afc_pkg::afc_thr_type rthr_r;
    logic [7:0] rdata_r;
    logic [3:0] tach_div_r;

    // Address decode
    wire hit_cfg1 = reg_addr == `AFC_OFS_CFG1;
    wire hit_fanchar = reg_addr == `AFC_OFS_FANCHAR;
    wire hit_minduty = reg_addr == `AFC_OFS_MINDUTY;
    wire hit_filt = reg_addr == `AFC_OFS_FILT;
    wire hit_lthr = reg_addr == `AFC_OFS_LTHR;
    wire hit_rthr = reg_addr == `AFC_OFS_RTHR;

    // Register writes; unused filter bit stays zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg1_r <= `AFC_RST_CFG1; // [R1]
            fanchar_r <= `AFC_RST_FANCHAR; // [R6] [R7]
            minduty_r <= `AFC_RST_MINDUTY; // [R3]
            filt_r <= `AFC_RST_FILT;
            lthr_r <= `AFC_RST_LTHR; // [R9]
            rthr_r <= `AFC_RST_RTHR; // [R11]
        end else if (reg_wr) begin
            if (hit_cfg1) cfg1_r <= reg_wdata;
            if (hit_fanchar) fanchar_r <= reg_wdata;
            if (hit_minduty) minduty_r <= {4'h0, reg_wdata[3:0]};
            if (hit_filt) filt_r <= reg_wdata & 8'hFD;
            if (hit_lthr) lthr_r <= reg_wdata;
            if (hit_rthr) rthr_r <= reg_wdata;
        end
    end

    // Read mux; unmapped offsets read zero
    wire [7:0] rd_mux = hit_cfg1 ? cfg1_r :
                        hit_fanchar ? fanchar_r :
                        hit_minduty ? minduty_r :
                        hit_filt ? filt_r :
                        hit_lthr ? lthr_r :
                        hit_rthr ? rthr_r : 8'h00;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end
    end
    assign reg_rdata = rdata_r;

    // Speed range divisor N = 1,2,4,8 for the tach counter [R8]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tach_div_r <= 4'h1;
        end else begin
            tach_div_r <= 4'h1 << fanchar_r[7:6];
        end
    end
    assign tach_div = tach_div_r;

    ////////////////////////////////////////////////////////////////////////////
    // Time base: us, ms and PWM slot enables from one clock

    // Slot length in us for each frequency code (240 slots a period)
    function automatic logic [8:0] slot_us(input logic [2:0] code);
        int chz;
        chz = 1170;
        unique case (code)
            3'd0: chz = 1170;
            3'd1: chz = 1560;
            3'd2: chz = 2340;
            3'd3: chz = 3125;
            3'd4: chz = 3750;
            3'd5: chz = 4690;
            3'd6: chz = 6250;
            3'd7: chz = 9350;
        endcase
        slot_us = 9'((100_000_000 + chz * 120) / (chz * `AFC_SLOTS));
    endfunction

    // Spin-up length in ms per code
    function automatic logic [13:0] spin_ms(input logic [2:0] code);
        spin_ms = 14'd200;
        unique case (code)
            3'd0: spin_ms = 14'd200;
            3'd1: spin_ms = 14'd400;
            3'd2: spin_ms = 14'd600;
            3'd3: spin_ms = 14'd800;
            3'd4: spin_ms = 14'd1000;
            3'd5: spin_ms = 14'd2000;
            3'd6: spin_ms = 14'd4000;
            3'd7: spin_ms = 14'd8000;
        endcase
    endfunction

    logic [15:0] us_cnt_r;
    logic [15:0] ms_cnt_r;
    logic [8:0] slot_cnt_r;
    logic [13:0] upd_cnt_r;
    wire us_tick = us_cnt_r == 16'(US_CYCLES - 1);
    wire ms_tick = us_tick && (ms_cnt_r == 16'(MS_US - 1));
    wire [8:0] slot_len = slot_us(fanchar_r[5:3]); // [R7]
    wire slot_tick = us_tick && (slot_cnt_r >= slot_len - 9'd1);
    // Updates per second double with each rate code [R15]
    wire [13:0] upd_ms = 14'(`AFC_SAMPLE_SLOW_MS) >> filt_r.rate;
    wire upd_tick = ms_tick && (upd_cnt_r >= upd_ms - 14'd1);

    // Free-running dividers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            us_cnt_r <= 16'h0000;
            ms_cnt_r <= 16'h0000;
            slot_cnt_r <= 9'h000;
            upd_cnt_r <= 14'h0000;
        end else begin
            us_cnt_r <= us_tick ? 16'h0000 : us_cnt_r + 16'h0001;
            if (us_tick) ms_cnt_r <= ms_tick ? 16'h0000 : ms_cnt_r + 16'h0001;
            if (us_tick) slot_cnt_r <= slot_tick ? 9'h000 : slot_cnt_r + 9'h001;
            if (ms_tick) upd_cnt_r <= upd_tick ? 14'h0000 : upd_cnt_r + 14'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel loops and channel selection
    logic l_run;
    logic r_run;
    logic [3:0] l_code;
    logic [3:0] r_code;

    afc_chan u_local (
        .mclk(mclk),
        .rst_n(rst_n),
        .temp(local_temp),
        .thr(lthr_r),
        .min_code(minduty_r[3:0]),
        .running(l_run),
        .duty_code(l_code)
    );

    afc_chan u_remote (
        .mclk(mclk),
        .rst_n(rst_n),
        .temp(remote_temp),
        .thr(rthr_r),
        .min_code(minduty_r[3:0]),
        .running(r_run),
        .duty_code(r_code)
    );

    wire auto_mode = cfg1_r[`AFC_CFG1_AUTO]; // [R1]
    wire both_ch = cfg1_r[`AFC_CFG1_CH_HI] & cfg1_r[`AFC_CFG1_CH_LO]; // [R2]
    // Only running channels compete; 11 takes the faster one [R19]
    wire [3:0] l_eff = l_run ? l_code : 4'h0;
    wire [3:0] r_eff = r_run ? r_code : 4'h0;
    wire [3:0] sel_code = both_ch ? ((l_eff > r_eff) ? l_eff : r_eff) : r_eff; // [R2] [R19]
    wire fan_on = auto_mode && (both_ch ? (l_run | r_run) : r_run);
    wire [7:0] target = 8'(sel_code * `AFC_SLOT_PER_CODE); // 16 slots a code [R4]

    ////////////////////////////////////////////////////////////////////////////
    // Fan sequencer: off, spin-up, run
    afc_pkg::afc_fan_st_type st_r;
    afc_pkg::afc_fan_st_type st_nxt;
    logic [13:0] spin_r;
    wire spin_done = spin_r == 14'h0000;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            afc_pkg::AFC_OFF:
                if (fan_on) st_nxt = filt_r.spin_dis ? afc_pkg::AFC_RUN : afc_pkg::AFC_SPIN; // [R20]
            afc_pkg::AFC_SPIN:
                if (!fan_on) st_nxt = afc_pkg::AFC_OFF;
                else if (spin_done) st_nxt = afc_pkg::AFC_RUN; // [R21]
            afc_pkg::AFC_RUN:
                if (!fan_on) st_nxt = afc_pkg::AFC_OFF;
            default: st_nxt = afc_pkg::AFC_OFF;
        endcase
    end

    // Spin timer loads on entry, counts ms ticks [R6]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= afc_pkg::AFC_OFF;
            spin_r <= 14'h0000;
        end else begin
            st_r <= st_nxt;
            if (st_r != afc_pkg::AFC_SPIN) spin_r <= spin_ms(fanchar_r[2:0]);
            else if (ms_tick && !spin_done) spin_r <= spin_r - 14'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Duty selection and filtered ramp
    logic [7:0] duty_r;
    wire [7:0] ramp = 8'h01 << filt_r.ramp; // 1,2,4,8 slots [R14]
    wire [8:0] up = {1'b0, duty_r} + {1'b0, ramp};
    wire [7:0] ramp_up = (up >= {1'b0, target}) ? target : up[7:0];
    wire [7:0] ramp_dn = (duty_r <= target + ramp) ? target : duty_r - ramp;
    wire [7:0] ramped = (duty_r < target) ? ramp_up : ramp_dn;
    // Filtered moves only on loop updates; plain tracks at once [R12] [R13]
    wire [7:0] run_duty = filt_r.en ? (upd_tick ? ramped : duty_r) : target;
    wire [7:0] duty_nxt = !auto_mode ? 8'(sw_duty_code * `AFC_SLOT_PER_CODE) :
                          (st_r == afc_pkg::AFC_OFF) ? 8'h00 : // [R22]
                          (st_r == afc_pkg::AFC_SPIN) ? 8'(`AFC_SLOTS) : // [R21]
                          run_duty; // [R14] [R15]

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            duty_r <= 8'h00;
            fan_running <= 1'b0;
            spin_active <= 1'b0;
        end else begin
            duty_r <= duty_nxt;
            fan_running <= st_r != afc_pkg::AFC_OFF;
            spin_active <= st_r == afc_pkg::AFC_SPIN;
        end
    end

    afc_pwm u_pwm (
        .mclk(mclk),
        .rst_n(rst_n),
        .slot_tick(slot_tick),
        .duty_slots(duty_r),
        .pwm_out(pwm_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_sw_duty;
        @(posedge mclk) disable iff (!rst_n)
        !auto_mode |=> duty_r == 8'($past(sw_duty_code) * 16);
    endproperty
    a_sw_duty: assert property (p_sw_duty) else $error("software duty not applied"); // [R1]

    property p_off_zero;
        @(posedge mclk) disable iff (!rst_n)
        auto_mode && st_r == afc_pkg::AFC_OFF |=> duty_r == 8'h00;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("duty not zero while off"); // [R22]

    property p_spin_full;
        @(posedge mclk) disable iff (!rst_n)
        auto_mode && st_r == afc_pkg::AFC_SPIN |=> duty_r == 8'd240;
    endproperty
    a_spin_full: assert property (p_spin_full) else $error("spin-up not full duty"); // [R21]

    property p_spin_entry;
        @(posedge mclk) disable iff (!rst_n)
        st_r == afc_pkg::AFC_OFF && fan_on && !filt_r.spin_dis |=> st_r == afc_pkg::AFC_SPIN;
    endproperty
    a_spin_entry: assert property (p_spin_entry) else $error("no spin-up on start"); // [R20]

    property p_unfilt;
        @(posedge mclk) disable iff (!rst_n)
        auto_mode && st_r == afc_pkg::AFC_RUN && !filt_r.en |=> duty_r == $past(target);
    endproperty
    a_unfilt: assert property (p_unfilt) else $error("unfiltered duty lagged"); // [R12]

    property p_hold;
        @(posedge mclk) disable iff (!rst_n)
        auto_mode && st_r == afc_pkg::AFC_RUN && filt_r.en && !upd_tick
            |=> duty_r == $past(duty_r);
    endproperty
    a_hold: assert property (p_hold) else $error("filtered duty moved off update"); // [R14]

    property p_step;
        @(posedge mclk) disable iff (!rst_n)
        auto_mode && st_r == afc_pkg::AFC_RUN && filt_r.en && upd_tick && duty_r < target
            |=> duty_r > $past(duty_r) && duty_r <= $past(duty_r) + 8'd8;
    endproperty
    a_step: assert property (p_step) else $error("ramp step wrong"); // [R14]

    property p_max;
        @(posedge mclk) disable iff (!rst_n)
        both_ch |-> sel_code >= l_eff && sel_code >= r_eff;
    endproperty
    a_max: assert property (p_max) else $error("faster channel not chosen"); // [R19]

    c_spin: cover property (@(posedge mclk) st_r == afc_pkg::AFC_SPIN ##1 st_r == afc_pkg::AFC_RUN);
    c_ramp: cover property (@(posedge mclk) filt_r.en && upd_tick && st_r == afc_pkg::AFC_RUN);
    c_both: cover property (@(posedge mclk) both_ch && l_run && r_run && l_eff > r_eff);
endmodule // afc_top

/* testbench/afc_fan_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Cooling fan on the drive output; it only sees the drive level and measures
// how long each high pulse lasts, in clocks
module afc_fan_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pwm_in,
    output logic [31:0] high_run_r,
    output logic [31:0] pulse_len_r,
    output logic [31:0] fall_cnt_r
);
    logic pwm_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // Width is latched on the falling edge, so a drive stuck high never reports
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pwm_d_r <= 1'b0;
            high_run_r <= 32'h0000_0000;
            pulse_len_r <= 32'h0000_0000;
            fall_cnt_r <= 32'h0000_0000;
        end else begin
            pwm_d_r <= pwm_in;
            high_run_r <= pwm_in ? high_run_r + 32'h0000_0001 : 32'h0000_0000;
            if (pwm_d_r && !pwm_in) begin
                pulse_len_r <= high_run_r;
                fall_cnt_r <= fall_cnt_r + 32'h0000_0001;
            end
        end
    end
endmodule // afc_fan_model

/* testbench/afc_top_tb.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Compare and count; prints at once on a mismatch
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
end

module afc_top_tb;
    localparam int SLOT = 45; // One slot at the fastest rate with a 1 us tick
    localparam int PERIOD = 240 * SLOT;
    localparam int STEP = 16 * SLOT; // One duty code, in clocks
    logic mclk, rst_n, reg_wr, reg_rd, pwm_out, fan_running, spin_active;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, local_temp, remote_temp;
    logic [3:0] sw_duty_code, tach_div;
    logic [31:0] high_run_r, pulse_len_r, fall_cnt_r, fall_base;
    int error_cnt = 0;
    int samples_checked = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Short time base: 1 clock per us, 4 us per ms, so spin-up 200 ms is 800
    afc_top #(.US_CYCLES(1), .MS_US(4)) afc_top_inst (
        .mclk(mclk),
        .rst_n(rst_n),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .local_temp(local_temp),
        .remote_temp(remote_temp),
        .sw_duty_code(sw_duty_code),
        .pwm_out(pwm_out),
        .fan_running(fan_running),
        .spin_active(spin_active),
        .tach_div(tach_div)
    );

    afc_fan_model afc_fan_model_inst (
        .mclk(mclk),
        .rst_n(rst_n),
        .pwm_in(pwm_out),
        .high_run_r(high_run_r),
        .pulse_len_r(pulse_len_r),
        .fall_cnt_r(fall_cnt_r)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog; the run needs about 107k clocks, the limit is 120k
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #1_200_000;
        error_cnt++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus access: one strobe cycle, inputs change on the falling edge
    task automatic summarize();
        $display("checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge mclk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge mclk);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        @(negedge mclk);
        `CHK(reg_rdata, exp)
    endtask

    // Bounded wait for n more falling edges of the drive
    task automatic wait_falls(input int n);
        fall_base = fall_cnt_r;
        for (int i = 0; i < 4 * PERIOD && fall_cnt_r < fall_base + n; i++) begin
            @(negedge mclk);
        end
        `CHK(fall_cnt_r >= fall_base + n, 1'b1)
    endtask

    // Second fall is always a pulse wholly latched after the change
    task automatic check_pulse(input logic [31:0] exp);
        wait_falls(2);
        `CHK(pulse_len_r, exp)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        local_temp = 8'h00;
        remote_temp = 8'h00;
        sw_duty_code = 4'h0;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        // Reset contents, unmapped place and read-as-zero bits
        check_reg(8'h00, 8'h80);
        check_reg(8'h20, 8'h1d);
        check_reg(8'h22, 8'h05);
        check_reg(8'h23, 8'h10);
        check_reg(8'h24, 8'h44);
        check_reg(8'h25, 8'h64);
        `CHK(tach_div, 4'h1)
        reg_write(8'h10, 8'hff);
        check_reg(8'h10, 8'h00);
        reg_write(8'h22, 8'hf8);
        check_reg(8'h22, 8'h08);
        reg_write(8'h23, 8'hff);
        check_reg(8'h23, 8'hfd);
        reg_write(8'h23, 8'h00);
        // Every speed range code; leaves fastest PWM and shortest spin-up
        for (int n = 0; n < 4; n++) begin
            reg_write(8'h20, {n[1:0], 6'h38});
            cycles(3);
            `CHK(tach_div, 4'h1 << n)
        end
        // Software duty code 8
        reg_write(8'h00, 8'h00);
        sw_duty_code = 4'h8;
        check_pulse(8 * STEP);
        // Remote only: threshold 8 C, range 40 C, minimum code 5, auto last
        reg_write(8'h25, 8'h13);
        reg_write(8'h22, 8'h05);
        reg_write(8'h23, 8'h00);
        reg_write(8'h00, 8'h80);
        remote_temp = 8'h08;
        local_temp = 8'h64; // Hot local side must be ignored here
        cycles(10);
        `CHK(fan_running, 1'b0)
        remote_temp = 8'h09;
        cycles(10);
        `CHK(spin_active, 1'b1)
        cycles(700);
        `CHK(spin_active, 1'b1)
        cycles(200);
        `CHK(spin_active, 1'b0)
        `CHK(fan_running, 1'b1)
        remote_temp = 8'h14;
        check_pulse(8 * STEP);
        // Hysteresis band: off only at threshold minus 5
        remote_temp = 8'h04;
        cycles(10);
        `CHK(fan_running, 1'b1)
        remote_temp = 8'h03;
        cycles(10);
        `CHK(fan_running, 1'b0)
        cycles(PERIOD + 100);
        `CHK(high_run_r, 32'h0000_0000)
        // Both channels: local 0 C, range 5 C clamps at 15 and wins
        reg_write(8'h24, 8'h00);
        local_temp = 8'h0a;
        remote_temp = 8'h14;
        reg_write(8'h00, 8'he0);
        cycles(2 * PERIOD + 200);
        `CHK(high_run_r > PERIOD, 1'b1)
        // Filtered: one slot per 125 ms update, so the fall to code 8 is slow
        // First fall ends the long full-duty run; the second is a whole pulse
        reg_write(8'h23, 8'h1d);
        local_temp = 8'h00;
        wait_falls(2);
        `CHK(pulse_len_r > 8 * STEP && pulse_len_r < PERIOD, 1'b1)
        summarize();
    end
endmodule // afc_top_tb
